// ### design/tcp_timer.sv
// Timer top: bus registers, time base, repetition and channels
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Update event on overflow or underflow only when repetition count is zero
// - Shadow registers reload once every N+1 overflows or underflows, N the repetition value
// - Repetition decrements on overflow up, underflow down, both in center mode
// - Repetition counter spans up to 128 periods; center mode refreshes twice
// - Software or slave update acts at once and reloads repetition count
// - Writing live repetition count shifts where the update flag appears
// - With slave mode 000 software drives enable, direction; update self-clears
// - Counter enable starts prescaler on the internal clock at once
// - Bus sees compare preload; only the shadow copy is compared
// - Mode 101 forces reference high, 100 forces it low
// - Match keeps, sets, clears or toggles output, with polarity applied
// - Match sets channel flag and requests interrupt when enabled
// - Compare shadow loads immediately unless preload enabled, then at update
// - Update event leaves output compare reference unchanged
// - Modes 110 and 111 select PWM 1 and PWM 2 per channel
// - Up PWM1 high below compare; full high above reload; zero low
// - Down PWM1 low above compare; high above reload; no zero duty
// - Center mode when field nonzero; flag direction follows the field
// - Five channels may use a separate compare value while counting down in center mode
// - Center mode counter write of zero or reload sets direction only
// - Update disable blocks updates; request source hides software update flag
// - Center counting goes 0 up to reload-1, then reload down to 1
module tcp_timer #(
  parameter int CH_N  = tcp_pkg::CH_N,
  parameter int CNT_W = tcp_pkg::CNT_W,
  parameter int REP_W = tcp_pkg::REP_W
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire logic            i_wb_cyc,
  input  wire logic            i_wb_stb,
  input  wire logic            i_wb_we,
  input  wire logic [7:0]      i_wb_adr,
  input  wire logic [31:0]     i_wb_dat,
  input  wire logic [3:0]      i_wb_sel,
  input  wire logic            i_slave_update,
  output logic      [31:0]     o_wb_dat,
  output logic                 o_wb_ack,
  output logic      [CH_N-1:0] o_channel_output,
  output logic      [CH_N-1:0] o_compare_reference,
  output logic                 o_irq_request,
  output logic                 o_update_event
);
  logic              ack_ff, nxt_ack;
  logic [31:0]       rdat_ff, nxt_rdat;
  logic              cen_ff, update_disable_bit_ff, urs_ff, dir_ff, reload_preload_enable_ff;
  logic              nxt_cen, nxt_update_disable_bit, nxt_urs, nxt_dir, nxt_reload_preload_enable;
  logic [1:0]        cms_ff, nxt_cms;
  logic [2:0]        sms_ff, nxt_sms;
  logic [CH_N:0]     ie_ff, nxt_ie, sr_ff, nxt_sr, sr_set;
  logic [CH_N*6-1:0] chm_ff, nxt_chm;
  logic [CH_N*2-1:0] cce_ff, nxt_cce;
  logic [CH_N-1:0]   phase_shift_enable_ff, nxt_phase_shift_enable;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt, psc_ff, nxt_psc, psc_sh_ff, nxt_psc_sh;
  logic [CNT_W-1:0]  pcnt_ff, nxt_pcnt, arr_ff, nxt_arr, arr_sh_ff, nxt_arr_sh;
  logic [REP_W-1:0]  rcr_ff, nxt_rcr, rep_count;
  logic [CNT_W-1:0]  ccr_ff  [CH_N];
  logic [CNT_W-1:0]  nxt_ccr [CH_N];
  logic [CNT_W-1:0]  ccrf_ff [CH_N];
  logic [CNT_W-1:0]  nxt_ccrf [CH_N];
  logic              step_ff, nxt_step, upd_ff, irq_ff, nxt_irq;
  logic              req, wr, tick, ovf, unf, rep_zero, hw_upd, sw_upd, upd;
  logic              ug_wr, cnt_wr, rep_wr;
  logic [31:0]       wval;
  logic [3:0]        lanes;
  logic [CH_N-1:0]   flag_set, ch_ref, ch_out;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  tcp_rep_counter #(
    .W (REP_W)
  ) u_rep (
    .i_core_clk         (i_core_clk),
    .i_rst              (i_rst),
    .i_period_end       (ovf || unf),
    .i_reload           (sw_upd),
    .i_live_write       (rep_wr),
    .i_live_value       (wval[REP_W-1:0]),
    .i_repetition_value (rcr_ff),
    .o_count            (rep_count),
    .o_at_zero          (rep_zero)
  );

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      tcp_channel #(
        .W (CNT_W)
      ) u_ch (
        .i_core_clk   (i_core_clk),
        .i_rst        (i_rst),
        .i_step       (step_ff),
        .i_update     (upd),
        .i_cnt        (cnt_ff),
        .i_arr        (arr_sh_ff),
        .i_dir        (dir_ff),
        .i_cms        (cms_ff),
        .i_mode       (chm_ff[g*6+tcp_pkg::CHM_MODE +: 3]),
        .i_preload_en (chm_ff[g*6+tcp_pkg::CHM_PE]),
        .i_sel        (chm_ff[g*6+tcp_pkg::CHM_SEL +: 2]),
        .i_out_en     (cce_ff[g*2]),
        .i_pol        (cce_ff[g*2+1]),
        .i_phase_en   (phase_shift_enable_ff[g]),
        .i_cmp_pre    (ccr_ff[g]),
        .i_cmpf_pre   (ccrf_ff[g]),
        .o_flag_set   (flag_set[g]),
        .o_ref        (ch_ref[g]),
        .o_out        (ch_out[g])
      );
    end
  endgenerate

  always_comb begin
    req    = i_wb_cyc && i_wb_stb && !ack_ff;
    wr     = req && i_wb_we;
    nxt_ack = req;
    wval   = 32'h0000_0000;
    lanes  = i_wb_we ? i_wb_sel : 4'h0;
    nxt_rdat = rdat_ff;
    nxt_cen = cen_ff;
    nxt_update_disable_bit = update_disable_bit_ff;
    nxt_urs = urs_ff;
    nxt_reload_preload_enable = reload_preload_enable_ff;
    nxt_cms = cms_ff;
    nxt_sms = sms_ff;
    nxt_ie = ie_ff;
    nxt_chm = chm_ff;
    nxt_cce = cce_ff;
    nxt_phase_shift_enable = phase_shift_enable_ff;
    nxt_psc = psc_ff;
    nxt_arr = arr_ff;
    nxt_rcr = rcr_ff;
    nxt_ccr = ccr_ff;
    nxt_ccrf = ccrf_ff;
    ug_wr  = 1'b0;
    cnt_wr = 1'b0;
    rep_wr = 1'b0;
    if (req) begin
      case (i_wb_adr)
        tcp_pkg::ADR_CTRL: begin
          wval = lane_merge({24'h000000, reload_preload_enable_ff, cms_ff, dir_ff, 1'b0, urs_ff,
                             update_disable_bit_ff, cen_ff}, i_wb_dat, lanes);
        end
        tcp_pkg::ADR_SLAVE:    wval = lane_merge({29'h0, sms_ff}, i_wb_dat, lanes);
        tcp_pkg::ADR_IRQ_EN:   wval = lane_merge(32'(ie_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_STATUS:   wval = lane_merge(32'h0, i_wb_dat, lanes);
        tcp_pkg::ADR_EVGEN:    wval = lane_merge(32'h0, i_wb_dat, lanes);
        tcp_pkg::ADR_CH_MODE:  wval = lane_merge(32'(chm_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_CH_EN:    wval = lane_merge(32'(cce_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_PHASE:    wval = lane_merge(32'(phase_shift_enable_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_COUNTER:  wval = lane_merge(32'(cnt_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_PRESCALE: wval = lane_merge(32'(psc_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_RELOAD:   wval = lane_merge(32'(arr_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_REPEAT:   wval = lane_merge(32'(rcr_ff), i_wb_dat, lanes);
        tcp_pkg::ADR_REP_LIVE: wval = lane_merge(32'(rep_count), i_wb_dat, lanes);
        default:               wval = 32'h0000_0000;
      endcase
      for (int i = 0; i < CH_N; i++) begin
        if (i_wb_adr == tcp_pkg::ADR_CMP0 + 8'(4*i)) begin
          wval = lane_merge(32'(ccr_ff[i]), i_wb_dat, lanes);
        end
        if (i_wb_adr == tcp_pkg::ADR_CMPF0 + 8'(4*i)) begin
          wval = lane_merge(32'(ccrf_ff[i]), i_wb_dat, lanes);
        end
      end
      // Read data: the current value of the addressed word, zero if unmapped
      nxt_rdat = wval;
      if (i_wb_adr == tcp_pkg::ADR_STATUS) begin
        nxt_rdat = 32'(sr_ff);
      end else if (i_wb_adr == tcp_pkg::ADR_EVGEN) begin
        nxt_rdat = 32'h0000_0000;
      end
    end
    if (wr) begin
      case (i_wb_adr)
        tcp_pkg::ADR_CTRL: begin
          nxt_cen  = wval[tcp_pkg::CTRL_CEN];
          nxt_update_disable_bit = wval[tcp_pkg::CTRL_UPDATE_DISABLE_BIT];
          nxt_urs  = wval[tcp_pkg::CTRL_URS];
          nxt_reload_preload_enable = wval[tcp_pkg::CTRL_RELOAD_PRELOAD_ENABLE];
          nxt_cms  = wval[tcp_pkg::CTRL_CMS +: 2];
        end
        tcp_pkg::ADR_SLAVE:    nxt_sms = wval[2:0];
        tcp_pkg::ADR_IRQ_EN:   nxt_ie = wval[CH_N:0];
        tcp_pkg::ADR_EVGEN:    ug_wr = wval[0];
        tcp_pkg::ADR_CH_MODE:  nxt_chm = wval[CH_N*6-1:0];
        tcp_pkg::ADR_CH_EN:    nxt_cce = wval[CH_N*2-1:0];
        tcp_pkg::ADR_PHASE:    nxt_phase_shift_enable = wval[CH_N-1:0];
        tcp_pkg::ADR_COUNTER:  cnt_wr = 1'b1;
        tcp_pkg::ADR_PRESCALE: nxt_psc = wval[CNT_W-1:0];
        tcp_pkg::ADR_RELOAD:   nxt_arr = wval[CNT_W-1:0];
        tcp_pkg::ADR_REPEAT:   nxt_rcr = wval[REP_W-1:0];
        tcp_pkg::ADR_REP_LIVE: rep_wr = 1'b1;
        default:               nxt_sms = sms_ff;
      endcase
      for (int i = 0; i < CH_N; i++) begin
        // bus writes reach the preload copy
        if (i_wb_adr == tcp_pkg::ADR_CMP0 + 8'(4*i)) begin
          nxt_ccr[i] = wval[CNT_W-1:0];
        end
        if (i_wb_adr == tcp_pkg::ADR_CMPF0 + 8'(4*i)) begin
          nxt_ccrf[i] = wval[CNT_W-1:0];
        end
      end
    end
  end

  always_comb begin
    tick     = cen_ff && (pcnt_ff == psc_sh_ff);
    nxt_pcnt = cen_ff ? (tick ? '0 : pcnt_ff + CNT_W'(1)) : pcnt_ff;
    nxt_cnt  = cnt_ff;
    ovf      = 1'b0;
    unf      = 1'b0;
    if (tick) begin
      if (cms_ff == tcp_pkg::CMS_EDGE) begin
        if (!dir_ff) begin
          if (cnt_ff >= arr_sh_ff) begin
            nxt_cnt = '0;
            ovf     = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end else if (cnt_ff == '0) begin
          nxt_cnt = arr_sh_ff;
          unf     = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end else if (!dir_ff) begin
        if (cnt_ff + CNT_W'(1) >= arr_sh_ff) begin
          nxt_cnt = arr_sh_ff;
          ovf     = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end else if (cnt_ff <= CNT_W'(1)) begin
        nxt_cnt = '0;
        unf     = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - CNT_W'(1);
      end
    end
    hw_upd = (ovf || unf) && rep_zero && !update_disable_bit_ff;
    sw_upd = (ug_wr || i_slave_update) && !update_disable_bit_ff;
    upd    = hw_upd || sw_upd;
    nxt_psc_sh = upd ? psc_ff : psc_sh_ff;
    nxt_arr_sh = (upd || !reload_preload_enable_ff) ? arr_ff : arr_sh_ff;
    nxt_dir    = dir_ff;
    // direction is hardware's in center mode
    if (wr && i_wb_adr == tcp_pkg::ADR_CTRL && cms_ff == tcp_pkg::CMS_EDGE) begin
      nxt_dir = wval[tcp_pkg::CTRL_DIR];
    end
    if (cms_ff != tcp_pkg::CMS_EDGE) begin
      if (ovf) begin
        nxt_dir = 1'b1;
      end else if (unf) begin
        nxt_dir = 1'b0;
      end
    end
    if (sw_upd) begin
      nxt_pcnt = '0;
      nxt_cnt  = (cms_ff == tcp_pkg::CMS_EDGE && dir_ff) ? arr_ff : '0;
    end
    if (cnt_wr) begin
      nxt_cnt = wval[CNT_W-1:0];
      if (cms_ff != tcp_pkg::CMS_EDGE) begin
        if (wval[CNT_W-1:0] == '0) begin
          nxt_dir = 1'b0;
        end else if (wval[CNT_W-1:0] == arr_sh_ff) begin
          nxt_dir = 1'b1;
        end
      end
    end
    nxt_step = tick || sw_upd || cnt_wr;
    // request source hides software update flag
    sr_set = {flag_set, hw_upd || (sw_upd && !urs_ff)};
    nxt_sr = (wr && i_wb_adr == tcp_pkg::ADR_STATUS) ? (sr_ff & ~wval[CH_N:0]) : sr_ff;
    nxt_sr = nxt_sr | sr_set;
    nxt_irq = |(nxt_sr & ie_ff);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h0000_0000;
      cen_ff    <= 1'b0;
      update_disable_bit_ff   <= 1'b0;
      urs_ff    <= 1'b0;
      dir_ff    <= 1'b0;
      reload_preload_enable_ff   <= 1'b0;
      cms_ff    <= tcp_pkg::CMS_EDGE;
      sms_ff    <= 3'h0;
      ie_ff     <= '0;
      sr_ff     <= '0;
      chm_ff    <= '0;
      cce_ff    <= '0;
      phase_shift_enable_ff   <= '0;
      cnt_ff    <= '0;
      psc_ff    <= '0;
      psc_sh_ff <= '0;
      pcnt_ff   <= '0;
      arr_ff    <= tcp_pkg::RST_RELOAD;
      arr_sh_ff <= tcp_pkg::RST_RELOAD;
      rcr_ff    <= '0;
      step_ff   <= 1'b0;
      upd_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      for (int i = 0; i < CH_N; i++) begin
        ccr_ff[i]  <= '0;
        ccrf_ff[i] <= '0;
      end
    end else begin
      ack_ff    <= nxt_ack;
      rdat_ff   <= nxt_rdat;
      cen_ff    <= nxt_cen;
      update_disable_bit_ff   <= nxt_update_disable_bit;
      urs_ff    <= nxt_urs;
      dir_ff    <= nxt_dir;
      reload_preload_enable_ff   <= nxt_reload_preload_enable;
      cms_ff    <= nxt_cms;
      sms_ff    <= nxt_sms;
      ie_ff     <= nxt_ie;
      sr_ff     <= nxt_sr;
      chm_ff    <= nxt_chm;
      cce_ff    <= nxt_cce;
      phase_shift_enable_ff   <= nxt_phase_shift_enable;
      cnt_ff    <= nxt_cnt;
      psc_ff    <= nxt_psc;
      psc_sh_ff <= nxt_psc_sh;
      pcnt_ff   <= nxt_pcnt;
      arr_ff    <= nxt_arr;
      arr_sh_ff <= nxt_arr_sh;
      rcr_ff    <= nxt_rcr;
      step_ff   <= nxt_step;
      upd_ff    <= upd;
      irq_ff    <= nxt_irq;
      for (int i = 0; i < CH_N; i++) begin
        ccr_ff[i]  <= nxt_ccr[i];
        ccrf_ff[i] <= nxt_ccrf[i];
      end
    end
  end

  assign o_wb_ack            = ack_ff;
  assign o_wb_dat            = rdat_ff;
  assign o_channel_output    = ch_out;
  assign o_compare_reference = ch_ref;
  assign o_irq_request       = irq_ff;
  assign o_update_event      = upd_ff;
endmodule
`default_nettype wire

// ### pkg/tcp_pkg.sv
// Constants for the timer compare and PWM block
package tcp_pkg;
  localparam int CNT_W = 16;
  localparam int CH_N  = 5;
  localparam int REP_W = 7;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_SLAVE    = 8'h04;
  localparam logic [7:0] ADR_IRQ_EN   = 8'h08;
  localparam logic [7:0] ADR_STATUS   = 8'h0C;
  localparam logic [7:0] ADR_EVGEN    = 8'h10;
  localparam logic [7:0] ADR_CH_MODE  = 8'h14;
  localparam logic [7:0] ADR_CH_EN    = 8'h18;
  localparam logic [7:0] ADR_PHASE    = 8'h1C;
  localparam logic [7:0] ADR_COUNTER  = 8'h20;
  localparam logic [7:0] ADR_PRESCALE = 8'h24;
  localparam logic [7:0] ADR_RELOAD   = 8'h28;
  localparam logic [7:0] ADR_REPEAT   = 8'h2C;
  localparam logic [7:0] ADR_REP_LIVE = 8'h30;
  localparam logic [7:0] ADR_CMP0     = 8'h34;
  localparam logic [7:0] ADR_CMPF0    = 8'h48;

  // Control register fields
  localparam int CTRL_CEN  = 0;
  localparam int CTRL_UPDATE_DISABLE_BIT = 1;
  localparam int CTRL_URS  = 2;
  localparam int CTRL_DIR  = 4;
  localparam int CTRL_CMS  = 5;
  localparam int CTRL_RELOAD_PRELOAD_ENABLE = 7;
  // Channel mode field: 6 bits per channel
  localparam int CHM_W    = 6;
  localparam int CHM_MODE = 0;
  localparam int CHM_PE   = 3;
  localparam int CHM_SEL  = 4;
  // Status: bit 0 update flag, bits 5:1 channel flags
  localparam int ST_UPD = 0;

  localparam logic [CNT_W-1:0] RST_RELOAD = 16'hFFFF;

  localparam logic [2:0] OCM_KEEP   = 3'h0;
  localparam logic [2:0] OCM_SET    = 3'h1;
  localparam logic [2:0] OCM_CLR    = 3'h2;
  localparam logic [2:0] OCM_TOGGLE = 3'h3;
  localparam logic [2:0] OCM_FLOW   = 3'h4;
  localparam logic [2:0] OCM_FHIGH  = 3'h5;
  localparam logic [2:0] OCM_PWM1   = 3'h6;
  localparam logic [2:0] OCM_PWM2   = 3'h7;

  localparam logic [1:0] CMS_EDGE = 2'h0;
  localparam logic [1:0] CMS_DOWN = 2'h1;
  localparam logic [1:0] CMS_UP   = 2'h2;
  localparam logic [1:0] SEL_OUT  = 2'h0;
endpackage

// ### design/tcp_rep_counter.sv
// Repetition down-counter with reload and live write
`timescale 1ns/1ns
`default_nettype none
module tcp_rep_counter #(
  parameter int W = 7
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic         i_period_end,
  input  wire logic         i_reload,
  input  wire logic         i_live_write,
  input  wire logic [W-1:0] i_live_value,
  input  wire logic [W-1:0] i_repetition_value,
  output logic      [W-1:0] o_count,
  output logic              o_at_zero
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (i_live_write) begin
      nxt_count = i_live_value;
    end else if (i_reload) begin
      nxt_count = i_repetition_value;
    end else if (i_period_end) begin
      nxt_count = (count_ff == '0) ? i_repetition_value : count_ff - W'(1);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign o_count   = count_ff;
  assign o_at_zero = (count_ff == '0);
endmodule
`default_nettype wire

// ### design/tcp_channel.sv
// One compare channel: shadow register, reference and output
`timescale 1ns/1ns
`default_nettype none
module tcp_channel #(
  parameter int W = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic         i_step,
  input  wire logic         i_update,
  input  wire logic [W-1:0] i_cnt,
  input  wire logic [W-1:0] i_arr,
  input  wire logic         i_dir,
  input  wire logic [1:0]   i_cms,
  input  wire logic [2:0]   i_mode,
  input  wire logic         i_preload_en,
  input  wire logic [1:0]   i_sel,
  input  wire logic         i_out_en,
  input  wire logic         i_pol,
  input  wire logic         i_phase_en,
  input  wire logic [W-1:0] i_cmp_pre,
  input  wire logic [W-1:0] i_cmpf_pre,
  output logic              o_flag_set,
  output logic              o_ref,
  output logic              o_out
);
  logic [W-1:0] cmp_ff, cmpf_ff, nxt_cmp, nxt_cmpf, cmp_use;
  logic         ref_ff, out_ff, nxt_ref, nxt_out, match, pwm1;

  always_comb begin
    nxt_cmp  = (!i_preload_en || i_update) ? i_cmp_pre : cmp_ff;
    nxt_cmpf = (!i_preload_en || i_update) ? i_cmpf_pre : cmpf_ff;
    // down half uses its own value
    cmp_use  = (i_phase_en && i_cms != tcp_pkg::CMS_EDGE && i_dir) ? cmpf_ff : cmp_ff;
    match    = i_step && (i_cnt == cmp_use);
    case (i_cms)
      tcp_pkg::CMS_DOWN: o_flag_set = match && i_dir;
      tcp_pkg::CMS_UP:   o_flag_set = match && !i_dir;
      default:           o_flag_set = match;
    endcase
    if (cmp_use > i_arr) begin
      pwm1 = 1'b1;
    end else if (i_cms == tcp_pkg::CMS_EDGE && i_dir) begin
      pwm1 = (i_cnt <= cmp_use);
    end else begin
      pwm1 = (i_cnt < cmp_use);
    end
    nxt_ref = ref_ff;
    if (i_sel == tcp_pkg::SEL_OUT) begin
      case (i_mode)
        tcp_pkg::OCM_KEEP:   nxt_ref = ref_ff;
        tcp_pkg::OCM_SET:    nxt_ref = match ? 1'b1 : ref_ff;
        tcp_pkg::OCM_CLR:    nxt_ref = match ? 1'b0 : ref_ff;
        tcp_pkg::OCM_TOGGLE: nxt_ref = match ? !ref_ff : ref_ff;
        tcp_pkg::OCM_FLOW:   nxt_ref = 1'b0;
        tcp_pkg::OCM_FHIGH:  nxt_ref = 1'b1;
        tcp_pkg::OCM_PWM1:   nxt_ref = pwm1;
        tcp_pkg::OCM_PWM2:   nxt_ref = !pwm1;
        default:             nxt_ref = ref_ff;
      endcase
    end
    nxt_out = i_out_en && (nxt_ref ^ i_pol);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_ff  <= '0;
      cmpf_ff <= '0;
      ref_ff  <= 1'b0;
      out_ff  <= 1'b0;
    end else begin
      cmp_ff  <= nxt_cmp;
      cmpf_ff <= nxt_cmpf;
      ref_ff  <= nxt_ref;
      out_ff  <= nxt_out;
    end
  end

  assign o_ref = ref_ff;
  assign o_out = out_ff;
endmodule
`default_nettype wire

// ### test/tcp_load_model.sv
// Load on the channel pins: counts the cycles each pin is high
`timescale 1ns/1ns
`default_nettype none
module tcp_load_model (
  input  wire logic            i_core_clk,
  input  wire logic            i_clear,
  input  wire logic [4:0]      i_pin,
  output var  logic [4:0][7:0] o_high_cnt
);
  logic [4:0][7:0] nxt_high_cnt;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      nxt_high_cnt[i] = i_clear ? 8'h00 : o_high_cnt[i] + {7'h00, i_pin[i]};
    end
  end
  always_ff @(posedge i_core_clk) begin
    o_high_cnt <= nxt_high_cnt;
  end
endmodule
`default_nettype wire

// ### test/tcp_timer_asserts.sv
// Checker on the timer ports: bus answer, updates and channel pins
`timescale 1ns/1ns
`default_nettype none
module tcp_timer_asserts #(
  parameter int CH_N  = 5,
  parameter int CNT_W = 16,
  parameter int REP_W = 7
) (
  input wire logic            i_core_clk,
  input wire logic            i_rst,
  input wire logic            i_wb_cyc,
  input wire logic            i_wb_stb,
  input wire logic            i_wb_we,
  input wire logic [7:0]      i_wb_adr,
  input wire logic [31:0]     i_wb_dat,
  input wire logic [3:0]      i_wb_sel,
  input wire logic            i_slave_update,
  input wire logic [31:0]     o_wb_dat,
  input wire logic            o_wb_ack,
  input wire logic [CH_N-1:0] o_channel_output,
  input wire logic [CH_N-1:0] o_compare_reference,
  input wire logic            o_irq_request,
  input wire logic            o_update_event
);
  typedef struct packed {
    logic       update_disable_bit;
    logic [5:0] chm;
    logic [1:0] chen;
    logic [5:0] irqe;
    logic [1:0] quiet;
  } tcp_shadow_t;
  tcp_shadow_t sh_ff;
  tcp_shadow_t nxt_sh;
  always_comb begin
    nxt_sh = sh_ff;
    if (sh_ff.quiet != 2'h3) nxt_sh.quiet = sh_ff.quiet + 2'h1;
    if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack) begin
      nxt_sh.quiet = 2'h0;
      if (i_wb_sel[0]) begin
        case (i_wb_adr)
          tcp_pkg::ADR_CTRL:    nxt_sh.update_disable_bit = i_wb_dat[tcp_pkg::CTRL_UPDATE_DISABLE_BIT];
          tcp_pkg::ADR_CH_MODE: nxt_sh.chm = i_wb_dat[5:0];
          tcp_pkg::ADR_CH_EN:   nxt_sh.chen = i_wb_dat[1:0];
          tcp_pkg::ADR_IRQ_EN:  nxt_sh.irqe = i_wb_dat[5:0];
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_ff <= '0;
    end else begin
      sh_ff <= nxt_sh;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  chk_slave_update: assert property (i_slave_update && !sh_ff.update_disable_bit |=> o_update_event)
    else $error("slave update lost");
  chk_update_disable_bit_blocks: assert property (sh_ff.quiet == 2'h3 && sh_ff.update_disable_bit |-> !o_update_event)
    else $error("update while disabled");
  chk_force_high: assert property (sh_ff.quiet == 2'h3 && sh_ff.chm == 6'h05
    |-> o_compare_reference[0])
    else $error("forced high missing");
  chk_force_low: assert property (sh_ff.quiet == 2'h3 && sh_ff.chm == 6'h04
    |-> !o_compare_reference[0])
    else $error("forced low missing");
  chk_out_polarity: assert property (sh_ff.quiet == 2'h3 && $stable(o_compare_reference[0])
    |-> o_channel_output[0] == (sh_ff.chen[0] & (o_compare_reference[0] ^ sh_ff.chen[1])))
    else $error("pin not ref with polarity");
  chk_irq_masked: assert property (sh_ff.quiet == 2'h3 && sh_ff.irqe == 6'h00
    |-> !o_irq_request)
    else $error("masked irq raised");
endmodule
bind tcp_timer tcp_timer_asserts #(.CH_N(CH_N), .CNT_W(CNT_W), .REP_W(REP_W)) i_chk (
  .i_core_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel,
  .i_slave_update, .o_wb_dat, .o_wb_ack, .o_channel_output, .o_compare_reference,
  .o_irq_request, .o_update_event);
`default_nettype wire

// ### test/tcp_timer_tb.sv
// Self-checking bench for the timer compare and PWM block
`timescale 1ns/1ns
`default_nettype none
module tcp_timer_tb;
  logic            clk, rst, cyc, stb, we, slv, clr, ack, irq, upd;
  logic [7:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     dat, rdat, q, seed;
  logic [4:0]      pin, refs;
  logic [4:0][7:0] hi;
  logic [31:0]     cv [4] = '{32'h3, 32'h3, 32'h0, 32'h9};
  logic [2:0]      om [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h5, 3'h4};
  logic [31:0]     oe [4] = '{32'h24, 32'h24, 32'h0, 32'h12};
  int              n_errors, comparisons, n_upd;
  tcp_timer i_dut (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .i_slave_update(slv),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_channel_output(pin), .o_compare_reference(refs),
    .o_irq_request(irq), .o_update_event(upd));
  tcp_load_model i_load (.i_core_clk(clk), .i_clear(clr), .i_pin(pin), .o_high_cnt(hi));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    if (upd === 1'b1) n_upd++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h80200003 : 32'h0);
  endfunction
  // High cycles of up-count PWM mode 1 with reload 8 over whole periods
  function automatic logic [31:0] duty(input logic [15:0] c, input int per);
    return (c > 16'h8) ? 32'(per * 9) : 32'(per * int'(c));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1,
                     input logic [3:0] s = 4'hF);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    check(q, e);
  endtask
  task automatic span(input int c);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    n_upd = 0;
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(100 * 5000);
    n_errors++;
    conclude();
  end
  initial begin
    {rst, cyc, stb, we, slv, clr} = 6'h20;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'hF;
    seed = 32'hB986;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(tcp_pkg::ADR_RELOAD, 32'hFFFF);
    rd(8'hFC, 32'h0);
    rd(tcp_pkg::ADR_EVGEN, 32'h0);
    bus(tcp_pkg::ADR_CMP0, 32'hABCD);
    bus(tcp_pkg::ADR_CMP0, 32'h1234, 1'b1, 4'h1);
    rd(tcp_pkg::ADR_CMP0, 32'hAB34);
    bus(tcp_pkg::ADR_RELOAD, 32'h8);
    foreach (cv[i]) bus(tcp_pkg::ADR_CMP0 + 8'(4 * i), cv[i]);
    bus(tcp_pkg::ADR_CH_MODE, 32'h38E3CE);
    bus(tcp_pkg::ADR_CH_EN, 32'h55);
    bus(tcp_pkg::ADR_EVGEN, 32'h1);
    bus(tcp_pkg::ADR_CTRL, 32'h81);
    repeat (4) @(posedge clk);
    span(36);
    check({24'h0, hi[0]}, duty(16'h3, 4));
    check({24'h0, hi[1]}, 32'h24 - duty(16'h3, 4));
    check({24'h0, hi[2]}, duty(16'h0, 4));
    check({24'h0, hi[3]}, duty(16'h9, 4));
    check(32'(n_upd), 32'h4);
    repeat (3) begin
      seed = lfsr(seed);
      bus(tcp_pkg::ADR_CMP0, {28'h0, seed[3:0]});
      repeat (12) @(posedge clk);
      span(36);
      check({24'h0, hi[0]}, duty({12'h0, seed[3:0]}, 4));
    end
    bus(tcp_pkg::ADR_IRQ_EN, 32'h2);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    bus(tcp_pkg::ADR_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(tcp_pkg::ADR_CMP0, 32'h3);
    for (int i = 0; i < 4; i++) begin
      bus(tcp_pkg::ADR_CH_MODE, 32'h38E3C0 | {29'h0, om[i]});
      repeat (12) @(posedge clk);
      span(36);
      check({24'h0, hi[0]}, oe[i]);
    end
    bus(tcp_pkg::ADR_REPEAT, 32'h2);
    bus(tcp_pkg::ADR_EVGEN, 32'h1);
    span(54);
    check(32'(n_upd), 32'h2);
    repeat (seed[4:0]) @(posedge clk);
    @(posedge clk);
    slv <= 1'b1;
    @(posedge clk);
    slv <= 1'b0;
    span(20);
    check(32'(n_upd), 32'h0);
    bus(tcp_pkg::ADR_CTRL, 32'h83);
    span(54);
    check(32'(n_upd), 32'h0);
    bus(tcp_pkg::ADR_CTRL, 32'h81);
    for (int i = 0; i < 2; i++) begin
      bus(tcp_pkg::ADR_CH_MODE, 32'h38E3C0 | {29'h0, om[4 + i]});
      bus(tcp_pkg::ADR_CH_EN, 32'h57);
      repeat (3) @(posedge clk);
      check({31'h0, refs[0]}, {31'h0, i == 0});
      check({31'h0, pin[0]}, {31'h0, i != 0});
    end
    bus(tcp_pkg::ADR_REPEAT, 32'h0);
    bus(tcp_pkg::ADR_CTRL, 32'hA1);
    bus(tcp_pkg::ADR_EVGEN, 32'h1);
    span(64);
    check(32'(n_upd), 32'h8);
    conclude();
  end
endmodule
`default_nettype wire
